// ==== rcf_cap.sv ====
// Capability register bank with guest-width request checker, Wishbone slave
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/10ps
module rcf_cap
    import rcf_pkg::*;
(
    input wire logic REF_CLK, // 25 MHz clock
    input wire logic ARST_N, // Asynchronous reset, active low
    input wire logic WB_CYC_I, // Wishbone cycle
    input wire logic WB_STB_I, // Wishbone strobe
    input wire logic WB_WE_I, // Wishbone write enable
    input wire logic [7:0] WB_ADR_I, // Wishbone byte address
    input wire logic [3:0] WB_SEL_I, // Wishbone byte selects
    input wire logic [31:0] WB_DAT_I, // Wishbone write data
    output logic [31:0] WB_DAT_O, // Wishbone read data
    output logic WB_ACK_O, // Wishbone acknowledge
    input wire rcf_req_s REQ, // Request from device side
    output rcf_rsp_s RSP, // Verdict, one cycle after request
    output logic [11:0] FRR_BASE_OFS, // Byte offset of first fault record
    output logic [8:0] FRR_COUNT // Number of fault records
);
    // Fixed capability word; only our fields, others read zero
    // Large pages 2MB and 1GB, so the field holds 0011b, a nested legal set
    // Zero-length reads are reported as allowed, the recommended setting
    // A 48-bit guest width covers the 40-bit host width with room to spare
    // Trade-off: one constant word costs no flops and can never drift
    localparam logic [63:0] CAP_WORD =
        (64'(LPS_VALUE) << LPS_LSB) | (64'(FRO_VALUE) << FRO_LSB) |
        (64'(ZLR_VALUE) << ZLR_BIT) | (64'(MAX_GUEST_ADDR_WIDTH_VALUE) << MAX_GUEST_ADDR_WIDTH_LSB) |
        (64'(NFR_VALUE) << NFR_LSB) | (64'(SUPPORTED_ADJUSTED_GUEST_WIDTHS_VALUE) << SUPPORTED_ADJUSTED_GUEST_WIDTHS_LSB);

    logic ack_reg; // Ack flop
    logic [31:0] rdat_reg; // Read data flop
    logic [1:0] adjusted_guest_width_sel_reg; // Software-chosen table width index
    logic [3:0] stat_reg; // Last verdict: valid, blocked, null, read permission
    rcf_rsp_s rsp_reg; // Verdict flop
    logic [11:0] frr_ofs_reg; // Fault record offset flop
    logic [8:0] frr_cnt_reg; // Fault record count flop
    logic [5:0] adjusted_guest_width_m1; // Table width minus one
    logic [5:0] limit_m1; // Effective width minus one
    logic over_lim; // Address above effective limit
    logic bus_req; // Access this cycle, not yet acked
    logic [31:0] rdat_next; // Read mux
    logic [1:0] wdat_sel; // Write data bits that pick the table width
    logic [6:0] limit_w; // Effective width in bits, for the checks below

    // Plain slices so the checks below can look back at them
    assign wdat_sel = WB_DAT_I[1:0];
    assign limit_w = 7'(limit_m1) + 7'h1;

    // A request counts once; the ack cycle masks it so a held strobe is not taken twice
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;

    // Table width from selected supported-width bit: 1->39, 2->48, 3->57
    always_comb begin
        case (adjusted_guest_width_sel_reg)
            2'h1: adjusted_guest_width_m1 = 6'd38;
            2'h2: adjusted_guest_width_m1 = 6'd47;
            2'h3: adjusted_guest_width_m1 = 6'd56;
            default: adjusted_guest_width_m1 = 6'd47; // Reserved code falls back to 48 bits
        endcase
    end

    // Smaller of guest limit and table width; field is width minus one
    assign limit_m1 = (MAX_GUEST_ADDR_WIDTH_VALUE < adjusted_guest_width_m1) ? MAX_GUEST_ADDR_WIDTH_VALUE : adjusted_guest_width_m1;

    // Comparator for the width limit
    rcf_limit u_limit (
        .addr(REQ.addr),
        .width_m1(limit_m1),
        .over(over_lim)
    );

    // Read mux; capability words constant so reads never change
    always_comb begin
        case (WB_ADR_I)
            CAP_LO_OFFSET: rdat_next = CAP_WORD[31:0];
            CAP_HI_OFFSET: rdat_next = CAP_WORD[63:32];
            CHK_CFG_OFFSET: rdat_next = {30'h0, adjusted_guest_width_sel_reg};
            CHK_STAT_OFFSET: rdat_next = {28'h0, stat_reg};
            default: rdat_next = 32'h0; // Unmapped reads zero, still acked
        endcase
    end

    // Bus answer one cycle after request; ack drops next cycle
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            rdat_reg <= bus_req ? rdat_next : 32'h0;
        end
    end

    // Only the checker config is writable; capability writes dropped
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            adjusted_guest_width_sel_reg <= ADJUSTED_GUEST_WIDTH_RESET;
        end else if (bus_req && WB_WE_I && WB_ADR_I == CHK_CFG_OFFSET && WB_SEL_I[0]) begin
            adjusted_guest_width_sel_reg <= WB_DAT_I[1:0];
        end
    end

    // Request verdict, registered so outputs come from flops
    // One verdict per request, back to back; there is no queue, so the
    // device side must take each verdict in the cycle it stands
    // DMA verdicts carry no permissions; only translations grant them
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= '0;
            if (REQ.valid) begin
                rsp_reg.valid <= 1'b1;
                case (REQ.kind)
                    RCF_REQ_DMA_RD: begin
                        // Over-limit blocked; zero-length to write-only per ZERO_LENGTH_READ_SUPPORT
                        rsp_reg.blocked <= over_lim ||
                            (REQ.zero_len && REQ.page_wr_only && !ZLR_VALUE);
                    end
                    RCF_REQ_DMA_WR: begin
                        rsp_reg.blocked <= over_lim;
                    end
                    RCF_REQ_XLATE: begin
                        // Null completion carries no permissions
                        rsp_reg.null_xlate <= over_lim;
                        rsp_reg.perm_r <= !over_lim;
                        rsp_reg.perm_w <= !over_lim;
                    end
                    default: begin
                        rsp_reg.blocked <= 1'b1; // Unknown kind is refused
                    end
                endcase
            end
        end
    end

    // Sticky copy of last verdict for software
    // Limitation: only the latest verdict is kept; faults are not logged here
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_reg <= 4'h0;
        end else if (rsp_reg.valid) begin
            stat_reg <= {1'b1, rsp_reg.blocked, rsp_reg.null_xlate, rsp_reg.perm_r};
        end
    end

    // Fault record placement for the recording logic
    // Held at zero in reset so the recording logic sees no stale placement
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            frr_ofs_reg <= 12'h0;
            frr_cnt_reg <= 9'h0;
        end else begin
            frr_ofs_reg <= 12'(FRO_VALUE) * 12'(FRR_STRIDE);
            frr_cnt_reg <= 9'(NFR_VALUE) + 9'h1;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;
    assign RSP = rsp_reg;
    assign FRR_BASE_OFS = frr_ofs_reg;
    assign FRR_COUNT = frr_cnt_reg;

    // Static checks on the fixed values
    a_lps_legal: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        CAP_WORD[37:34] inside {4'h0, 4'h1, 4'h3})
        else $error("large page field illegal");
    a_lps_bits: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        CAP_WORD[37:36] == 2'b00)
        else $error("reserved large page bits set");
    a_zlr_set: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        CAP_WORD[ZLR_BIT] == 1'b1)
        else $error("zero length read not reported");
    a_max_guest_addr_width_host: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        CAP_WORD[21:16] >= HAW_VALUE)
        else $error("guest width below host width");
    a_supported_adjusted_guest_widths_rsvd: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        CAP_WORD[8] == 1'b0 && CAP_WORD[12] == 1'b0)
        else $error("reserved width bits set");
    a_frr_place: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $past(ARST_N) |-> (FRR_BASE_OFS == 12'(CAP_WORD[33:24]) * 12'h10))
        else $error("fault record offset wrong");
    a_frr_count: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        $past(ARST_N) |-> (FRR_COUNT == 9'(CAP_WORD[47:40]) + 9'h1))
        else $error("fault record count wrong");
    // Reads of the high capability word always return the constant
    a_cap_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        bus_req && !WB_WE_I && WB_ADR_I == CAP_HI_OFFSET |=> WB_DAT_O == CAP_WORD[63:32])
        else $error("capability high read changed");
    // DMA above limit is blocked on the next cycle
    sequence s_dma_over;
        REQ.valid && REQ.kind inside {RCF_REQ_DMA_RD, RCF_REQ_DMA_WR} && over_lim;
    endsequence
    a_dma_block: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_dma_over |=> RSP.valid && RSP.blocked)
        else $error("over-limit dma not blocked");
    a_xlate_null: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid && REQ.kind == RCF_REQ_XLATE && over_lim
        |=> RSP.null_xlate && !RSP.perm_r && !RSP.perm_w)
        else $error("over-limit translation not null");
    a_limit_min: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        limit_m1 <= MAX_GUEST_ADDR_WIDTH_VALUE && limit_m1 <= adjusted_guest_width_m1)
        else $error("limit not the minimum width");
    a_zlr_pass: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid && REQ.kind == RCF_REQ_DMA_RD && !over_lim && REQ.zero_len
        |=> !RSP.blocked)
        else $error("zero length read blocked");

    // Bus handshake: a fresh request is answered exactly one cycle later
    sequence s_bus_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence

    a_bus_answer: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_bus_take |=> WB_ACK_O)
        else $error("bus request not acknowledged");

    // Ack is a single-cycle pulse, so a held strobe cannot be taken twice
    a_ack_pulse: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    // Read data is zero outside the ack cycle
    a_rdat_idle: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero while idle");

    // Low capability word read returns the constant
    sequence s_cap_lo_rd;
        bus_req && !WB_WE_I && WB_ADR_I == CAP_LO_OFFSET;
    endsequence

    a_cap_lo_read: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_cap_lo_rd |=> WB_DAT_O == CAP_WORD[31:0])
        else $error("capability low read changed");

    // Writes to the capability words leave the width select alone
    a_cap_wr_drop: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        bus_req && WB_WE_I && (WB_ADR_I == CAP_LO_OFFSET || WB_ADR_I == CAP_HI_OFFSET)
        |=> $stable(adjusted_guest_width_sel_reg))
        else $error("capability write had an effect");

    // Width select write lands in the next cycle
    a_cfg_write: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        bus_req && WB_WE_I && WB_ADR_I == CHK_CFG_OFFSET && WB_SEL_I[0]
        |=> adjusted_guest_width_sel_reg == $past(wdat_sel))
        else $error("width select write lost");

    // Every request gets exactly one verdict, one cycle later
    a_rsp_follow: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid |=> RSP.valid)
        else $error("request without verdict");
    a_rsp_quiet: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        !REQ.valid |=> !RSP.valid)
        else $error("verdict without request");

    // Limit comparator agrees with a shift of the address by the width
    a_limit_cmp: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid |-> over_lim == ((REQ.addr >> limit_w) != 64'h0))
        else $error("limit comparison wrong");

    // In-range DMA proceeds
    a_dma_pass: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid && REQ.kind inside {RCF_REQ_DMA_RD, RCF_REQ_DMA_WR} && !over_lim
        && !REQ.zero_len |=> !RSP.blocked && !RSP.null_xlate)
        else $error("in-range dma blocked");

    // In-range translation is granted both permissions
    sequence s_xlate_in;
        REQ.valid && REQ.kind == RCF_REQ_XLATE && !over_lim;
    endsequence

    a_xlate_grant: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        s_xlate_in |=> RSP.perm_r && RSP.perm_w && !RSP.null_xlate && !RSP.blocked)
        else $error("in-range translation not granted");

    // Unused request code is refused
    a_kind_refuse: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        REQ.valid && REQ.kind == RCF_REQ_NONE |=> RSP.blocked)
        else $error("unknown request kind not refused");

    // Status word copies the verdict one cycle after it stands
    a_stat_copy: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
        RSP.valid |=> stat_reg == {1'b1, $past(RSP.blocked), $past(RSP.null_xlate),
        $past(RSP.perm_r)})
        else $error("status copy wrong");
endmodule // rcf_cap

// ==== rcf_cap_tb.sv ====
// Self-checking testbench for the capability bank and its request checker
`timescale 1ns/10ps
module rcf_cap_tb;
    import rcf_pkg::*;
    logic REF_CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [7:0] WB_ADR_I; // Byte address
    logic [3:0] WB_SEL_I; // Byte selects, all on
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic [11:0] FRR_BASE_OFS;
    logic [8:0] FRR_COUNT;
    rcf_req_s cmd, req; // Bench command and request from the device model
    rcf_rsp_s rsp; // Verdict from the unit
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] rd_q[$]; // Expected read data, oldest first
    logic [4:0] rs_q[$]; // Expected verdict {translate, blocked, null, r, w}
    logic [4:0] e; // Verdict note being compared
    // Capability words: 37:34 pages, 33:24 record offset, 22 zero-length, 21:16 width, 12:8 widths
    localparam logic [31:0] CAP_LO = {FRO_VALUE[7:0], 1'b0, ZLR_VALUE, MAX_GUEST_ADDR_WIDTH_VALUE, 3'h0,
        SUPPORTED_ADJUSTED_GUEST_WIDTHS_VALUE, 8'h00};
    localparam logic [31:0] CAP_HI = {16'h0000, NFR_VALUE, 2'h0, LPS_VALUE, FRO_VALUE[9:8]};
    rcf_cap uut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .REQ(req), .RSP(rsp),
        .FRR_BASE_OFS(FRR_BASE_OFS), .FRR_COUNT(FRR_COUNT));
    rcf_dev dev (.clk(REF_CLK), .cmd(cmd), .req(req));
    // 25 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end
    // Count and report one comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Classic single bus cycle; for reads d is the expected data
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int i;
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, adr, d};
        if (!we) rd_q.push_back(d);
        for (i = 0; i < 16; i++) begin
            @(posedge REF_CLK);
            if (WB_ACK_O === 1'b1) break;
        end
        if (i == 16) begin
            bad_count++;
            end_of_test();
        end
        {WB_CYC_I, WB_STB_I} <= 2'b00;
        @(posedge REF_CLK);
    endtask
    // One request per cycle; expected verdict from the limit width w
    task automatic rq(input rcf_req_e k, input logic [63:0] a, input logic zl, input int w);
        logic ov;
        ov = (a >> w) != 64'h0;
        cmd <= '{1'b1, k, a, zl, zl};
        rs_q.push_back(k == RCF_REQ_XLATE ? {1'b1, 1'b0, ov, ~ov, ~ov} :
            (k == RCF_REQ_NONE ? 5'b01000 : {1'b0, ov, 3'b000}));
        @(posedge REF_CLK);
    endtask
    // Watch answers and compare with the oldest note; DMA permissions are not compared
    always @(posedge REF_CLK) begin
        if (WB_ACK_O === 1'b1 && !WB_WE_I) check(WB_DAT_O, rd_q.pop_front());
        if (rsp.valid === 1'b1) begin
            e = rs_q.pop_front();
            check({28'h0, {rsp.blocked, rsp.null_xlate, rsp.perm_r, rsp.perm_w} &
                (e[4] ? 4'hf : 4'hc)}, {28'h0, e[3:0]});
        end
    end
    // Main sequence
    initial begin
        int w;
        w = $urandom(32'h8d6ff347);
        ARST_N = 1'b0;
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = '0;
        WB_SEL_I = 4'hf;
        cmd = '0;
        repeat (10) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        check({20'h0, FRR_BASE_OFS}, {22'h0, FRO_VALUE} * 32'h10);
        check({23'h0, FRR_COUNT}, {24'h0, NFR_VALUE} + 32'h1);
        wb(1'b0, CAP_LO_OFFSET, CAP_LO);
        wb(1'b0, CAP_HI_OFFSET, CAP_HI);
        wb(1'b1, CAP_LO_OFFSET, $urandom);
        wb(1'b1, CAP_HI_OFFSET, $urandom);
        wb(1'b0, CAP_LO_OFFSET, CAP_LO);
        wb(1'b0, CAP_HI_OFFSET, CAP_HI);
        wb(1'b0, 8'h40, 32'h0);
        // Each table width select; the guest limit caps the 57-bit choice at 48 bits
        for (int j = 0; j < 4; j++) begin
            w = (j == 1) ? 39 : 48;
            wb(1'b1, CHK_CFG_OFFSET, 32'(j));
            for (int k = 0; k < 3; k++) begin
                rq(rcf_req_e'(k), (64'h1 << w) - 64'h1, 1'b0, w);
                rq(rcf_req_e'(k), 64'h1 << w, 1'b0, w);
            end
            rq(RCF_REQ_DMA_RD, 64'h1000, 1'b1, w);
            repeat (6) rq(rcf_req_e'(2'($urandom_range(2, 0))),
                {$urandom, $urandom} >> $urandom_range(30, 10), 1'b0, w);
            cmd.valid <= 1'b0;
        end
        repeat (4) @(posedge REF_CLK);
        // Refused kind, then the status and select words read back
        rq(RCF_REQ_NONE, 64'h0, 1'b0, 48);
        cmd.valid <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        wb(1'b0, CHK_STAT_OFFSET, 32'hc);
        wb(1'b0, CHK_CFG_OFFSET, 32'h3);
        check(32'(rs_q.size() + rd_q.size()), 32'h0);
        end_of_test();
    end
endmodule // rcf_cap_tb

// ==== rcf_dev.sv ====
// Model of an I/O device that issues requests to the check port
`timescale 1ns/10ps
module rcf_dev
    import rcf_pkg::*;
(
    input wire logic clk, // Unit clock
    input wire rcf_req_s cmd, // Request the bench wants issued
    output rcf_req_s req // Request presented to the unit
);
    // Launch on the edge; an idle address keeps toggling so stale values never look valid
    always_ff @(posedge clk) begin
        req <= cmd;
        if (!cmd.valid) begin
            req.addr <= ~req.addr;
        end
    end
endmodule // rcf_dev

// ==== rcf_limit.sv ====
// Address-width limit comparator used by the check unit
`timescale 1ns/10ps
module rcf_limit
    import rcf_pkg::*;
(
    input wire logic [63:0] addr, // Address to check
    input wire logic [5:0] width_m1, // Width minus one
    output logic over // Address above 2^(width)-1
);
    // Any bit at or above the width sets the flag
    always_comb begin
        over = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (i > int'(width_m1) && addr[i]) begin
                over = 1'b1;
            end
        end
    end
endmodule // rcf_limit

// ==== rcf_pkg.sv ====
// Package with capability field layout, fixed values and bus constants for the remap block
package rcf_pkg;
    // Register offsets (byte addresses of 32-bit words)
    localparam logic [7:0] CAP_LO_OFFSET = 8'h08; // Capability bits 31:0
    localparam logic [7:0] CAP_HI_OFFSET = 8'h0c; // Capability bits 63:32
    localparam logic [7:0] CHK_CFG_OFFSET = 8'h10; // Check unit: page-table width select
    localparam logic [7:0] CHK_STAT_OFFSET = 8'h14; // Check unit: last verdict
    // Field positions inside the 64-bit capability word
    localparam int LPS_LSB = 34; // Large-page field 37:34
    localparam int FRO_LSB = 24; // Fault-record offset 33:24
    localparam int ZLR_BIT = 22; // Zero-length read bit
    localparam int MAX_GUEST_ADDR_WIDTH_LSB = 16; // Max guest width 21:16
    localparam int NFR_LSB = 40; // Fault-record count 47:40
    localparam int SUPPORTED_ADJUSTED_GUEST_WIDTHS_LSB = 8; // Supported widths 12:8
    // Fixed implementation values
    localparam logic [3:0] LPS_VALUE = 4'h3; // 2MB and 1GB pages
    localparam logic [9:0] FRO_VALUE = 10'h020; // First fault record at base + 0x200
    localparam logic ZLR_VALUE = 1'b1; // Zero-length reads allowed
    localparam logic [5:0] MAX_GUEST_ADDR_WIDTH_VALUE = 6'h2f; // 48-bit guest width
    localparam logic [7:0] NFR_VALUE = 8'h07; // Eight fault records
    localparam logic [4:0] SUPPORTED_ADJUSTED_GUEST_WIDTHS_VALUE = 5'h06; // 39-bit and 48-bit tables
    localparam logic [5:0] HAW_VALUE = 6'h27; // Platform host width minus one (40 bits)
    localparam logic [7:0] FRR_STRIDE = 8'h10; // Bytes per fault record slot
    // Width codes for the page-table structure (index into supported widths)
    localparam logic [1:0] ADJUSTED_GUEST_WIDTH_RESET = 2'h2; // Reset select: 48-bit tables
    // Request kinds at the check port
    typedef enum logic [1:0] {
        RCF_REQ_DMA_RD = 2'b00, // Untranslated DMA read
        RCF_REQ_DMA_WR = 2'b01, // Untranslated DMA write
        RCF_REQ_XLATE = 2'b10, // Device-TLB translation request
        RCF_REQ_NONE = 2'b11 // Unused code
    } rcf_req_e;
    // Request carrier
    typedef struct packed {
        logic valid; // Request present this cycle
        rcf_req_e kind; // Request kind
        logic [63:0] addr; // Guest address
        logic zero_len; // Zero-length read
        logic page_wr_only; // Target page is write-only
    } rcf_req_s;
    // Verdict carrier
    typedef struct packed {
        logic valid; // Verdict present
        logic blocked; // DMA blocked, report fault
        logic null_xlate; // Null completion, R=W=0
        logic perm_r; // Read permission of completion
        logic perm_w; // Write permission of completion
    } rcf_rsp_s;
endpackage
